/* File: hdl/usart_spi_master.sv */
// Behaviour
// - Data-empty interrupt needs its enable, global enable and empty buffer.
// - Receiver enable in SPI mode takes the serial input pin.
// - Disabling the receiver flushes all unread received data.
// - Receiver alone makes no transfers; only the transmitter clocks.
// - Transmitter enable in SPI mode takes the serial output pin.
// - Disabled transmitter stays active until shifter and buffer are empty.
// - Inactive transmitter hands the output pin back to the port.
// - Mode field bits 7:6: async, sync, reserved, master SPI.
// - Frame fields are taken in the same write that enters SPI mode.
// - Bit 2 set sends LSB first, clear sends MSB first.
// - Bit 1 picks sampling on leading or trailing clock edge.
// - Bit 0 sets clock polarity; both give the four SPI modes.
// - Baud divider registers set the clock rate as in UART use.
// - Writing the data register starts a full-duplex transfer.
// - Empty flag is set whenever the buffer is free, and after reset.
// - Transmit-complete sets at frame end with no data pending; write one clears.
`timescale 1ns/100ps
`include "usart_spi_defines.svh"
module usart_spi_master (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // Serial pins
    output logic serial_out_o,
    output logic serial_out_oe,
    output logic transfer_clock_o,
    output logic transfer_clock_oe,
    input wire logic serial_in_i,
    output logic serial_in_override,
    // Interrupt
    output logic irq
);
    usart_spi_pkg::ctl_state_t q;
    usart_spi_pkg::ctl_state_t n;
    logic sin;
    logic take;
    logic spi_on;
    logic tx_active;
    logic frame_end;
    logic lead;
    logic [7:0] rd_val;

    baud_if bl ();

    bit_sync2 u_sync (
        .ref_clk(ref_clk),
        .reset(reset),
        .d(serial_in_i),
        .q(sin)
    );

    baud_gen u_baud (
        .ref_clk(ref_clk),
        .reset(reset),
        .bl(bl)
    );

    assign bl.en = (q.st == usart_spi_pkg::ST_SHIFT);
    assign bl.div = {q.baud_hi, q.baud_lo};

    assign take = hsel & htrans[1] & hready;
    assign spi_on = (q.mode == usart_spi_pkg::MODE_SPI);
    assign tx_active = q.txen | (q.st == usart_spi_pkg::ST_SHIFT) | q.txbuf_v;
    assign lead = ~q.half[0];
    assign frame_end = (q.st == usart_spi_pkg::ST_SHIFT) && bl.tick && (q.half == `LAST_HALF);

    // Register read view
    always_comb begin
        case (q.ap_addr)
            `REG_STATUS: begin
                rd_val = {q.rx_cnt != 2'h0, q.txc, ~q.txbuf_v, 5'h00};
            end
            `REG_CTRL_B: begin
                rd_val = {q.rxcie, q.txcie, q.data_empty_irq_enable, q.rxen, q.txen, `B_RSVD_READ};
            end
            `REG_CTRL_C: begin
                rd_val = {q.mode, 3'h0, q.order, q.cpha, q.cpol};
            end
            `REG_DATA: begin
                rd_val = q.rx_mem[q.rx_head];
            end
            `REG_BAUD_LO: begin
                rd_val = q.baud_lo;
            end
            `REG_BAUD_HI: begin
                rd_val = {4'h0, q.baud_hi};
            end
            `REG_GIE: begin
                rd_val = {7'h00, q.gie};
            end
            `REG_IRQ_STAT: begin
                rd_val = {5'h00, q.irq_stat};
            end
            `REG_IRQ_MASK: begin
                rd_val = {5'h00, q.irq_mask};
            end
            default: begin
                rd_val = 8'h00;
            end
        endcase
    end

    always_comb begin
        n = q;
        // Bus address phase; reads get one wait state
        n.ap_v = take & hwrite;
        n.rd_pend = take & ~hwrite;
        if (take) begin
            n.ap_addr = haddr[7:0];
        end
        // Read data phase, popping the receive buffer on a data read
        if (q.rd_pend) begin
            n.rdata = {24'h00_0000, rd_val};
            if (q.ap_addr == `REG_DATA && q.rx_cnt != 2'h0) begin
                n.rx_head = ~q.rx_head;
                n.rx_cnt = q.rx_cnt - 2'h1;
            end
        end
        // Write data phase
        if (q.ap_v) begin
            case (q.ap_addr)
                `REG_STATUS: begin
                    if (hwdata[`A_TXC]) begin
                        n.txc = 1'b0;
                    end
                end
                `REG_CTRL_B: begin
                    n.rxcie = hwdata[7];
                    n.txcie = hwdata[6];
                    n.data_empty_irq_enable = hwdata[5];
                    n.rxen = hwdata[4];
                    n.txen = hwdata[3];
                    // Bits 2:0 are not stored
                end
                `REG_CTRL_C: begin
                    n.mode = usart_spi_pkg::mode_t'(hwdata[7:6]);
                    n.order = hwdata[2];
                    n.cpha = hwdata[1];
                    n.cpol = hwdata[0];
                    // Bits 5:3 are not stored
                end
                `REG_DATA: begin
                    if (!q.txbuf_v && q.txen) begin
                        n.txbuf = hwdata[7:0];
                        n.txbuf_v = 1'b1;
                    end
                end
                `REG_BAUD_LO: begin
                    n.baud_lo = hwdata[7:0];
                end
                `REG_BAUD_HI: begin
                    n.baud_hi = hwdata[3:0];
                end
                `REG_GIE: begin
                    n.gie = hwdata[0];
                end
                `REG_IRQ_STAT: begin
                    n.irq_stat = q.irq_stat & ~hwdata[2:0];
                end
                `REG_IRQ_MASK: begin
                    n.irq_mask = hwdata[2:0];
                end
                default: begin
                end
            endcase
        end
        // Transfer engine; hardware sets follow bus clears so they win
        case (q.st)
            usart_spi_pkg::ST_IDLE: begin
                n.sck = q.cpol;
                if (q.txbuf_v && spi_on) begin
                    n.tx_sh = q.txbuf;
                    n.txbuf_v = 1'b0;
                    n.half = 4'h0;
                    n.st = usart_spi_pkg::ST_SHIFT;
                    n.irq_stat[`IRQ_EMPTY] = 1'b1;
                end
            end
            usart_spi_pkg::ST_SHIFT: begin
                if (bl.tick) begin
                    n.sck = ~q.sck;
                    n.half = q.half + 4'h1;
                    // Sample on leading edge for phase 0, trailing for phase 1
                    if (q.cpha ? ~lead : lead) begin
                        n.rx_sh = q.order ? {sin, q.rx_sh[7:1]} : {q.rx_sh[6:0], sin};
                    end
                    // Change output on the opposite edge; phase 1 skips the first
                    if (q.cpha ? (lead && q.half != 4'h0) : ~lead) begin
                        n.tx_sh = q.order ? {1'b0, q.tx_sh[7:1]} : {q.tx_sh[6:0], 1'b0};
                    end
                    if (q.half == `LAST_HALF) begin
                        n.st = usart_spi_pkg::ST_IDLE;
                        if (q.rxen && n.rx_cnt != `RX_DEPTH) begin
                            // When full the newest byte is lost
                            n.rx_mem[n.rx_head ^ n.rx_cnt[0]] = n.rx_sh;
                            n.rx_cnt = n.rx_cnt + 2'h1;
                            n.irq_stat[`IRQ_RXC] = 1'b1;
                        end
                        if (!n.txbuf_v) begin
                            n.txc = 1'b1;
                            n.irq_stat[`IRQ_TXC] = 1'b1;
                        end
                    end
                end
            end
            default: begin
                n.st = usart_spi_pkg::ST_IDLE;
            end
        endcase
        if (!q.rxen) begin
            n.rx_cnt = 2'h0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            q <= '0;
            q.order <= `ORDER_RESET;
            q.cpha <= `PHASE_RESET;
            q.cpol <= `POLARITY_RESET;
        end else begin
            q <= n;
        end
    end

    assign hreadyout = ~q.rd_pend;
    assign hrdata = q.rdata;
    assign hresp = 1'b0;
    assign serial_out_o = q.order ? q.tx_sh[0] : q.tx_sh[7];
    assign serial_out_oe = tx_active & spi_on;
    assign transfer_clock_o = q.sck;
    assign transfer_clock_oe = tx_active & spi_on;
    assign serial_in_override = q.rxen & spi_on;
    assign irq = q.gie & ((q.data_empty_irq_enable & ~q.txbuf_v)
        | (q.txcie & q.txc)
        | (q.rxcie & (q.rx_cnt != 2'h0))
        | (|(q.irq_stat & q.irq_mask)));

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    sequence s_tx_quiet;
        q.st == usart_spi_pkg::ST_IDLE && !q.txbuf_v && !q.txen;
    endsequence

    sequence s_idle_two;
        (q.st == usart_spi_pkg::ST_IDLE && $stable(q.cpol))[*2];
    endsequence

    property p_empty_irq;
        (q.gie && q.data_empty_irq_enable && !q.txbuf_v) |-> irq;
    endproperty
    a_empty_irq: assert property (p_empty_irq) else $error("empty irq missing");

    property p_no_empty_irq;
        (q.irq_mask == 3'h0 && !q.txcie && !q.rxcie && !(q.data_empty_irq_enable && q.gie && !q.txbuf_v)) |-> !irq;
    endproperty
    a_no_empty_irq: assert property (p_no_empty_irq) else $error("spurious irq");

    property p_flush;
        !q.rxen |=> q.rx_cnt == 2'h0;
    endproperty
    a_flush: assert property (p_flush) else $error("rx not flushed");

    property p_rx_only;
        s_tx_quiet |=> q.st == usart_spi_pkg::ST_IDLE ##1 q.st == usart_spi_pkg::ST_IDLE;
    endproperty
    a_rx_only: assert property (p_rx_only) else $error("transfer without tx");

    property p_tx_pin;
        (q.txen && spi_on) |-> serial_out_oe && transfer_clock_oe;
    endproperty
    a_tx_pin: assert property (p_tx_pin) else $error("tx pin not taken");

    property p_drain;
        (!q.txen && spi_on && q.st == usart_spi_pkg::ST_SHIFT) |-> serial_out_oe;
    endproperty
    a_drain: assert property (p_drain) else $error("tx released early");

    property p_release;
        s_tx_quiet |-> !serial_out_oe;
    endproperty
    a_release: assert property (p_release) else $error("tx pin held");

    property p_empty_after_reset;
        $fell(reset) |-> !q.txbuf_v && q.st == usart_spi_pkg::ST_IDLE;
    endproperty
    a_empty_after_reset: assert property (p_empty_after_reset) else $error("not empty at reset");

    property p_txc_set;
        (frame_end && !q.txbuf_v && !(q.ap_v && q.ap_addr == `REG_DATA)) |=> q.txc;
    endproperty
    a_txc_set: assert property (p_txc_set) else $error("txc not set");

    property p_idle_level;
        s_idle_two |-> transfer_clock_o == q.cpol;
    endproperty
    a_idle_level: assert property (p_idle_level) else $error("idle clock level");

    property p_frame_len;
        (q.st == usart_spi_pkg::ST_IDLE ##1 q.st == usart_spi_pkg::ST_SHIFT) |-> q.half == 4'h0;
    endproperty
    a_frame_len: assert property (p_frame_len) else $error("frame start count");

    sequence s_load;
        q.st == usart_spi_pkg::ST_IDLE && q.txbuf_v && spi_on;
    endsequence

    // Loading the shifter frees the buffer and flags the event
    property p_load;
        s_load |=> q.st == usart_spi_pkg::ST_SHIFT && !q.txbuf_v && q.irq_stat[`IRQ_EMPTY];
    endproperty
    a_load: assert property (p_load) else $error("buffer not loaded");

    property p_rx_push;
        (frame_end && q.rxen && q.rx_cnt == 2'h0) |=> q.rx_cnt == 2'h1;
    endproperty
    a_rx_push: assert property (p_rx_push) else $error("rx byte not kept");

    property p_sck_toggle;
        (q.st == usart_spi_pkg::ST_SHIFT && bl.tick) |=> transfer_clock_o != $past(transfer_clock_o);
    endproperty
    a_sck_toggle: assert property (p_sck_toggle) else $error("clock edge missing");

    property p_data_refused;
        (q.ap_v && q.ap_addr == `REG_DATA && !q.txen && !q.txbuf_v) |=> !q.txbuf_v;
    endproperty
    a_data_refused: assert property (p_data_refused) else $error("data taken without tx");

    property p_mode_gate;
        (!spi_on && q.st == usart_spi_pkg::ST_IDLE) |=> q.st == usart_spi_pkg::ST_IDLE;
    endproperty
    a_mode_gate: assert property (p_mode_gate) else $error("transfer outside SPI mode");

endmodule : usart_spi_master

/* File: include/usart_spi_defines.svh */
`ifndef USART_SPI_DEFINES_SVH
`define USART_SPI_DEFINES_SVH

// Register byte offsets on the AHB-Lite slave
`define REG_STATUS 8'h00
`define REG_CTRL_B 8'h04
`define REG_CTRL_C 8'h08
`define REG_DATA 8'h0c
`define REG_BAUD_LO 8'h10
`define REG_BAUD_HI 8'h14
`define REG_GIE 8'h18
`define REG_IRQ_STAT 8'h1c
`define REG_IRQ_MASK 8'h20

// Status register bit positions
`define A_RXC 7
`define A_TXC 6
`define A_EMPTY 5

// Reserved low bits of control B read back with this pattern
`define B_RSVD_READ 3'h6

// Control C reset values of the frame fields
`define ORDER_RESET 1'b1
`define PHASE_RESET 1'b1
`define POLARITY_RESET 1'b0

// Sticky event bits in the interrupt status and mask registers
`define IRQ_TXC 0
`define IRQ_RXC 1
`define IRQ_EMPTY 2

// Sixteen clock half periods per 8-bit frame, numbered 0 to 15
`define LAST_HALF 4'hf
`define RX_DEPTH 2'h2

`endif

/* File: include/usart_spi_pkg.sv */
package usart_spi_pkg;

    typedef enum logic [1:0] {
        MODE_ASYNC = 2'b00,
        MODE_SYNC = 2'b01,
        MODE_RSVD = 2'b10,
        MODE_SPI = 2'b11
    } mode_t;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_SHIFT = 1'b1
    } xfer_state_t;

    typedef struct packed {
        logic rxcie;
        logic txcie;
        logic data_empty_irq_enable;
        logic rxen;
        logic txen;
        mode_t mode;
        logic order;
        logic cpha;
        logic cpol;
        logic [7:0] baud_lo;
        logic [3:0] baud_hi;
        logic gie;
        logic [2:0] irq_stat;
        logic [2:0] irq_mask;
        xfer_state_t st;
        logic [7:0] txbuf;
        logic txbuf_v;
        logic [7:0] tx_sh;
        logic [7:0] rx_sh;
        logic [3:0] half;
        logic sck;
        logic txc;
        logic [1:0][7:0] rx_mem;
        logic rx_head;
        logic [1:0] rx_cnt;
        logic ap_v;
        logic [7:0] ap_addr;
        logic rd_pend;
        logic [31:0] rdata;
    } ctl_state_t;

    typedef struct packed {
        logic [11:0] cnt;
        logic tick;
    } baud_state_t;

    typedef struct packed {
        logic meta;
        logic sync;
    } sync_state_t;

endpackage : usart_spi_pkg

/* File: include/baud_if.sv */
`timescale 1ns/100ps
interface baud_if;
    logic en;
    logic [11:0] div;
    logic tick;
    modport ctl (output en, output div, input tick);
    modport gen (input en, input div, output tick);
endinterface : baud_if

/* File: hdl/bit_sync2.sv */
`timescale 1ns/100ps
module bit_sync2 (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Level in and out
    input wire logic d,
    output logic q
);
    usart_spi_pkg::sync_state_t s_q;
    usart_spi_pkg::sync_state_t s_d;

    always_comb begin
        s_d.meta = d;
        s_d.sync = s_q.meta;
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign q = s_q.sync;
endmodule : bit_sync2

/* File: hdl/baud_gen.sv */
`timescale 1ns/100ps
module baud_gen (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Divider control
    baud_if.gen bl
);
    usart_spi_pkg::baud_state_t s_q;
    usart_spi_pkg::baud_state_t s_d;

    // One tick every div+1 cycles, first tick div+1 cycles after enable
    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (!bl.en) begin
            s_d.cnt = bl.div;
        end else if (s_q.cnt == 12'h000) begin
            s_d.cnt = bl.div;
            s_d.tick = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt - 12'h001;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign bl.tick = s_q.tick;
endmodule : baud_gen

/* File: bench/spi_slave_model.sv */
`timescale 1ns/100ps
module spi_slave_model (
    // Reference clock for the idle pattern
    input wire logic ref_clk,
    // Link pins
    input wire logic sck,
    input wire logic mosi,
    input wire logic link_oe,
    output logic miso,
    // Frame setup from the bench
    input wire logic cpol,
    input wire logic cpha,
    input wire logic lsb_first,
    input wire logic [7:0] reply,
    output logic [7:0] heard
);
    int pos = 0;
    int out_idx = 8;
    logic junk = 1'b0;

    function automatic int bit_at(input int k);
        return lsb_first ? k : 7 - k;
    endfunction : bit_at

    task automatic arm();
        pos = 0;
        out_idx = cpha ? 8 : 0;
    endtask : arm

    always @(posedge ref_clk) begin
        junk <= ~junk;
    end

    // Sample on one edge kind, shift on the other
    always @(sck) begin
        if (sck === ~(cpol ^ cpha)) begin
            heard[bit_at(pos)] = mosi;
            pos = (pos == 7) ? 0 : pos + 1;
            if (pos == 0) begin
                out_idx = 8;
            end
        end else begin
            out_idx = pos;
        end
    end

    // Released line toggles so stale data is never taken for a bit
    assign miso = (link_oe && out_idx < 8) ? reply[bit_at(out_idx)] : junk;
endmodule : spi_slave_model

/* File: bench/tb_top.sv */
`timescale 1ns/100ps
`include "usart_spi_defines.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin failures++; \
    $display("mismatch at %0t: got %h expected %h", $time, g, e); end end
module tb_top;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata;
    logic hreadyout, serial_out_o, serial_out_oe, transfer_clock_o, transfer_clock_oe;
    logic serial_in_i, serial_in_override, irq, hresp;
    logic s_cpol = 1'b0, s_cpha = 1'b0, s_lsb = 1'b0;
    logic [7:0] s_reply = 8'h00;
    logic [7:0] s_heard;
    int failures = 0, checks = 0, edges = 0;
    realtime t_prev = 0.0, t_last = 0.0;

    usart_spi_master usart_spi_master_i (
        .ref_clk(ref_clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .serial_out_o(serial_out_o), .serial_out_oe(serial_out_oe),
        .transfer_clock_o(transfer_clock_o), .transfer_clock_oe(transfer_clock_oe),
        .serial_in_i(serial_in_i), .serial_in_override(serial_in_override), .irq(irq)
    );
    spi_slave_model slave_i (
        .ref_clk(ref_clk), .sck(transfer_clock_o), .mosi(serial_out_o), .link_oe(transfer_clock_oe),
        .miso(serial_in_i), .cpol(s_cpol), .cpha(s_cpha), .lsb_first(s_lsb), .reply(s_reply),
        .heard(s_heard)
    );

    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end

    always @(transfer_clock_o) begin
        edges++;
        t_prev = t_last;
        t_last = $realtime;
    end

    task automatic end_of_test();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test

    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        if (n >= 20) begin
            failures++;
            end_of_test();
        end
    endtask : wait_ready

    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] v);
        @(posedge ref_clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        wait_ready();
        htrans <= 2'b00;
        hwdata <= {24'h00_0000, d};
        wait_ready();
        v = hrdata;
        @(negedge ref_clk);
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] v;
        bus(1'b1, a, d, v);
        `CHK(hresp, 1'b0)
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        logic [31:0] v;
        bus(1'b0, a, 8'h00, v);
        `CHK(v, {24'h00_0000, e})
    endtask : rdc

    task automatic wait_status(input logic [7:0] m);
        logic [31:0] v;
        int n;
        n = 0;
        do begin
            bus(1'b0, `REG_STATUS, 8'h00, v);
            n++;
        end while ((v[7:0] & m) === 8'h00 && n < 200);
        if (n >= 200) begin
            failures++;
            end_of_test();
        end
    endtask : wait_status

    function automatic logic [7:0] ctl_c(input int k);
        return {5'b11000, k[2:0]};
    endfunction : ctl_c

    initial begin
        repeat (90000) @(posedge ref_clk);
        failures++;
        end_of_test();
    end

    initial begin
        logic [7:0] d;
        int baud;
        void'($urandom(32'h1472_41a6));
        repeat (20) @(posedge ref_clk);
        reset <= 1'b0;
        @(negedge ref_clk);
        `CHK(irq, 1'b0)
        rdc(`REG_STATUS, 8'h20);
        rdc(`REG_CTRL_B, 8'h06);
        rdc(`REG_CTRL_C, 8'h06);
        for (int m = 0; m < 3; m++) begin
            wr(`REG_CTRL_C, {m[1:0], 6'h06});
            wr(`REG_CTRL_B, 8'h08);
            rdc(`REG_CTRL_C, {m[1:0], 6'h06});
            `CHK(transfer_clock_oe, 1'b0)
        end
        // Receiver alone: the data write must not start a frame
        wr(`REG_CTRL_C, 8'hc0);
        wr(`REG_CTRL_B, 8'h10);
        edges = 0;
        wr(`REG_DATA, 8'h5a);
        repeat (40) @(posedge ref_clk);
        `CHK(edges, 0)
        `CHK(serial_in_override, 1'b1)
        `CHK(serial_out_oe, 1'b0)
        rdc(`REG_STATUS, 8'h20);
        for (int k = 0; k < 8; k++) begin
            d = 8'($urandom);
            baud = 3 + int'($urandom % 4);
            s_reply = 8'($urandom);
            {s_lsb, s_cpha, s_cpol} = k[2:0];
            wr(`REG_BAUD_LO, 8'(baud));
            wr(`REG_BAUD_HI, 8'h00);
            wr(`REG_CTRL_C, ctl_c(k));
            rdc(`REG_CTRL_C, ctl_c(k));
            wr(`REG_CTRL_B, 8'h18);
            `CHK(serial_out_oe, 1'b1)
            slave_i.arm();
            edges = 0;
            wr(`REG_DATA, d);
            wait_status(8'h40);
            `CHK(s_heard, d)
            rdc(`REG_DATA, s_reply);
            `CHK(edges, 16)
            `CHK(transfer_clock_o, s_cpol)
            `CHK(int'((t_last - t_prev) / 5.0), baud + 1)
            wr(`REG_STATUS, 8'h40);
            rdc(`REG_STATUS, 8'h20);
        end
        // Two queued bytes, transmitter switched off while busy
        {s_lsb, s_cpha, s_cpol} = 3'b000;
        wr(`REG_CTRL_C, 8'hc0);
        slave_i.arm();
        wr(`REG_DATA, 8'h3c);
        wr(`REG_DATA, 8'hc3);
        rdc(`REG_STATUS, 8'h00);
        wr(`REG_CTRL_B, 8'h10);
        `CHK(serial_out_oe, 1'b1)
        wait_status(8'h40);
        `CHK(serial_out_oe, 1'b0)
        `CHK(transfer_clock_oe, 1'b0)
        `CHK(s_heard, 8'hc3)
        rdc(`REG_STATUS, 8'he0);
        wr(`REG_CTRL_B, 8'h00);
        rdc(`REG_STATUS, 8'h60);
        `CHK(serial_in_override, 1'b0)
        wr(`REG_IRQ_MASK, 8'h00);
        wr(`REG_GIE, 8'h00);
        wr(`REG_CTRL_B, 8'h20);
        `CHK(irq, 1'b0)
        wr(`REG_GIE, 8'h01);
        `CHK(irq, 1'b1)
        wr(`REG_CTRL_B, 8'h00);
        `CHK(irq, 1'b0)
        wr(`REG_IRQ_MASK, 8'h01);
        `CHK(irq, 1'b1)
        rdc(`REG_IRQ_STAT, 8'h07);
        wr(`REG_IRQ_STAT, 8'h07);
        rdc(`REG_IRQ_STAT, 8'h00);
        `CHK(irq, 1'b0)
        rdc(8'h30, 8'h00);
        end_of_test();
    end
endmodule : tb_top
